// ==== rtl/sssr_regs.svh ====
// Constants for the supervisor state save and restore sequencer.
// Assumes inclusion from the package, the sequencer module and the testbench only.
`ifndef SSSR_REGS_SVH
`define SSSR_REGS_SVH
`define SSSR_VCSR_INIT     32'h0000_1f80
`define SSSR_VCSR_LEGAL    32'h0000_ffff
`define SSSR_TS_BIT        3
`define SSSR_ALIGN_BITS    6
`define SSSR_HDR_PRES_OFS  64'h0000_0000_0000_0200
`define SSSR_HDR_COMP_OFS  64'h0000_0000_0000_0208
`define SSSR_HDR_RSVD_OFS  64'h0000_0000_0000_0210
`define SSSR_HDR_RSVD_WRDS 3'h6
`define SSSR_COMP_BIT      63
`define SSSR_VEC_COMP      1
`define SSSR_NCOMP         64
`endif

// ==== rtl/sssr_pkg.sv ====
// Types shared by the save and restore sequencer.
// Assumes the constants header is on the include path.
`include "sssr_regs.svh"
package sssr_pkg;
    typedef enum logic [2:0] {
        SSSR_IDLE  = 3'b000,
        SSSR_WPRES = 3'b001,
        SSSR_WCOMP = 3'b011,
        SSSR_RHDR  = 3'b010,
        SSSR_RWAIT = 3'b110,
        SSSR_APPLY = 3'b111,
        SSSR_DONE  = 3'b101
    } sssr_state_t;
    typedef enum logic [1:0] {
        SSSR_F_NONE = 2'h0,
        SSSR_F_UD   = 2'h1,
        SSSR_F_NM   = 2'h2,
        SSSR_F_GP   = 2'h3
    } sssr_fault_t;
endpackage : sssr_pkg

// ==== rtl/sssr_seq.sv ====
// Sequencer for privileged compacted save and restore of extended state.
// Assumes a word memory port that answers reads exactly one cycle later.
//
// How it works
// - Requested mask is instruction mask AND (user OR supervisor enable).
// - Undefined opcode if save feature off, else unavailable if task flag.
// - Protection fault if privilege above zero or area not 64-byte aligned.
// - Save writes present bit as zero if unrequested, else in-use bit.
// - If component 1 requested, vector control not 1F80H forces present bit 1 and full save.
// - Save writes compaction bitmap: bit 63 set, bits 62:0 requested mask.
// - Save touches only the present and compaction words of the header.
// - Components 0,1 legacy; 2..62 extended, always compacted.
// - Save skips components whose in-use bit is zero, vector case aside.
// - Modified optimization only when last restore record matches.
// - Under modified optimization, skip components with modified bit zero, component 1 aside.
// - Restore reads header; fault if compaction 63 clear or bit not enabled.
// - Fault if present bit outside compaction bitmap or header tail nonzero.
// - Requested present-zero component is initialised; vector control 1F80H.
// - Requested component with present one is loaded from the save area.
// - Supervisor component with unsupported or reserved bits set faults.
// - Illegal vector control value on restore faults.
// - Faulting supervisor restore may leave prior, loaded or initial values.
// - Restore: unrequested in-use kept; present ones set; others cleared.
// - Restore sets modified for unrequested; requested cleared here.
// - Restore records privilege, guest flag, area address, compaction bitmap.
`timescale 1ns/1ps
`default_nettype none
`include "sssr_regs.svh"
module sssr_seq #(
    parameter int NCOMP = `SSSR_NCOMP
) (
    // Clock and reset.
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Instruction request.
    input  wire logic                 start_save,
    input  wire logic                 start_restore,
    input  wire logic [63:0]          instr_mask,
    input  wire logic [63:0]          area_addr,
    // Core control state.
    input  wire logic [63:0]          user_enable_mask,
    input  wire logic [63:0]          sup_enable_mask,
    input  wire logic                 save_feature_enable,
    input  wire logic [31:0]          ctrl_flags,
    input  wire logic [1:0]           cur_priv,
    input  wire logic                 guest_mode,
    input  wire logic [31:0]          vcsr_in,
    // Component legality from the per-component checkers.
    input  wire logic [63:0]          sup_comp_mask,
    input  wire logic [63:0]          comp_bad_value,
    // Memory port to the save area.
    output logic                      mem_wr,
    output logic                      mem_rd,
    output logic [63:0]               mem_addr,
    output logic [63:0]               mem_wdata,
    input  wire logic [63:0]          mem_rdata,
    // Component transfer commands.
    output logic [63:0]               comp_save,
    output logic [63:0]               comp_load,
    output logic [63:0]               comp_init,
    output logic                      vcsr_init,
    // Tracking state.
    input  wire logic [63:0]          in_use_set,
    input  wire logic [63:0]          modified_set,
    output logic [63:0]               in_use_q,
    output logic [63:0]               modified_q,
    // Completion.
    output logic                      done,
    output sssr_pkg::sssr_fault_t     fault
);
    import sssr_pkg::*;

    sssr_state_t      state_q;
    logic             is_save_q;
    logic [63:0]      requested_component_mask_q;
    logic [63:0]      addr_q;
    logic [63:0]      pres_q;
    logic [63:0]      comp_q;
    logic [2:0]       widx_q;
    logic             tail_bad_q;
    logic             vcsr_bad_q;
    logic [1:0]       rec_priv_q;
    logic             rec_guest_q;
    logic [63:0]      rec_addr_q;
    logic [63:0]      rec_bitmap_q;

    function automatic logic [63:0] req_mask(input logic [63:0] m,
                                             input logic [63:0] u,
                                             input logic [63:0] s);
        req_mask = m & (u | s);
    endfunction : req_mask

    // ------------------------------------------------------------------
    // Entry checks.
    // ------------------------------------------------------------------
    logic          start;
    sssr_fault_t   entry_fault;
    logic [63:0]   requested_component_mask_now;
    logic [63:0]   enabled;
    logic [63:0]   pres_save;
    logic [63:0]   comp_save_bm;
    logic          mod_opt;

    assign start    = start_save | start_restore;
    assign requested_component_mask_now = req_mask(instr_mask, user_enable_mask,
                               sup_enable_mask);
    assign enabled  = user_enable_mask | sup_enable_mask;

    always_comb begin
        if (!save_feature_enable) begin
            entry_fault = SSSR_F_UD;
        end else if (ctrl_flags[`SSSR_TS_BIT]) begin
            entry_fault = SSSR_F_NM;
        end else if (cur_priv != 2'h0 ||
                     area_addr[`SSSR_ALIGN_BITS-1:0] != 6'h00) begin
            entry_fault = SSSR_F_GP;
        end else begin
            entry_fault = SSSR_F_NONE;
        end
    end

    // ------------------------------------------------------------------
    // Save bitmaps.
    // ------------------------------------------------------------------
    always_comb begin
        pres_save = requested_component_mask_q & in_use_q;
        if (requested_component_mask_q[`SSSR_VEC_COMP] && vcsr_in != `SSSR_VCSR_INIT) begin
            pres_save[`SSSR_VEC_COMP] = 1'b1;
        end
        comp_save_bm = {1'b1, requested_component_mask_q[62:0]};
    end

    assign mod_opt = rec_priv_q == cur_priv && rec_guest_q == guest_mode &&
                     rec_addr_q == addr_q && rec_bitmap_q[`SSSR_COMP_BIT] &&
                     rec_bitmap_q[62:0] == requested_component_mask_q[62:0];

    // ------------------------------------------------------------------
    // Sequencer.
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q    <= SSSR_IDLE;
            is_save_q  <= 1'b0;
            requested_component_mask_q     <= 64'h0;
            addr_q     <= 64'h0;
            pres_q     <= 64'h0;
            comp_q     <= 64'h0;
            widx_q     <= 3'h0;
            tail_bad_q <= 1'b0;
            vcsr_bad_q <= 1'b0;
            fault      <= SSSR_F_NONE;
            done       <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state_q)
                SSSR_IDLE: begin
                    if (start) begin
                        fault <= entry_fault;
                        if (entry_fault != SSSR_F_NONE) begin
                            done <= 1'b1;
                        end else begin
                            is_save_q  <= start_save;
                            requested_component_mask_q     <= requested_component_mask_now;
                            addr_q     <= area_addr;
                            widx_q     <= 3'h0;
                            tail_bad_q <= 1'b0;
                            vcsr_bad_q <= 1'b0;
                            state_q    <= start_save ? SSSR_WPRES : SSSR_RHDR;
                        end
                    end
                end
                SSSR_WPRES: state_q <= SSSR_WCOMP;
                SSSR_WCOMP: state_q <= SSSR_DONE;
                SSSR_RHDR: begin
                    // Present, compaction and six reserved words in turn.
                    widx_q <= widx_q + 3'h1;
                    if (widx_q == 3'h7) begin
                        state_q <= SSSR_RWAIT;
                    end
                end
                SSSR_RWAIT: state_q <= SSSR_APPLY;
                SSSR_APPLY: state_q <= SSSR_DONE;
                SSSR_DONE: begin
                    done    <= 1'b1;
                    state_q <= SSSR_IDLE;
                    if (!is_save_q && (!comp_q[`SSSR_COMP_BIT] ||
                        (comp_q[62:0] & ~enabled[62:0]) != 63'h0 ||
                        (pres_q & ~comp_q) != 64'h0 || tail_bad_q)) begin
                        fault <= SSSR_F_GP;
                    end else if (!is_save_q &&
                        ((requested_component_mask_q & pres_q & sup_comp_mask & comp_bad_value)
                         != 64'h0 || vcsr_bad_q)) begin
                        fault <= SSSR_F_GP;
                    end
                end
                default: state_q <= SSSR_IDLE;
            endcase
            // Header words arrive one cycle after each read.
            if (state_q == SSSR_RHDR && widx_q != 3'h0 ||
                state_q == SSSR_RWAIT) begin
                if (widx_q == 3'h1) begin
                    pres_q <= mem_rdata;
                end else if (widx_q == 3'h2) begin
                    comp_q <= mem_rdata;
                end else if (mem_rdata != 64'h0) begin
                    tail_bad_q <= 1'b1;
                end
            end
            if (state_q == SSSR_RWAIT && requested_component_mask_q[`SSSR_VEC_COMP] &&
                (vcsr_in & ~`SSSR_VCSR_LEGAL) != 32'h0) begin
                vcsr_bad_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Memory port; only the two header words are written on save.
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_wr    <= 1'b0;
            mem_rd    <= 1'b0;
            mem_addr  <= 64'h0;
            mem_wdata <= 64'h0;
        end else begin
            mem_wr <= 1'b0;
            mem_rd <= 1'b0;
            if (state_q == SSSR_WPRES) begin
                mem_wr    <= 1'b1;
                mem_addr  <= addr_q + `SSSR_HDR_PRES_OFS;
                mem_wdata <= pres_save;
            end else if (state_q == SSSR_WCOMP) begin
                mem_wr    <= 1'b1;
                mem_addr  <= addr_q + `SSSR_HDR_COMP_OFS;
                mem_wdata <= comp_save_bm;
            end else if (state_q == SSSR_RHDR) begin
                mem_rd    <= 1'b1;
                mem_addr  <= addr_q + `SSSR_HDR_PRES_OFS +
                             {58'h0, widx_q, 3'h0};
            end
        end
    end

    // ------------------------------------------------------------------
    // Component commands; placement is legacy for 0,1 and compacted
    // beyond, resolved by the component movers.
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            comp_save <= 64'h0;
            comp_load <= 64'h0;
            comp_init <= 64'h0;
            vcsr_init <= 1'b0;
        end else begin
            comp_save <= 64'h0;
            comp_load <= 64'h0;
            comp_init <= 64'h0;
            vcsr_init <= 1'b0;
            if (state_q == SSSR_WCOMP) begin
                comp_save <= pres_save & (mod_opt ?
                    (modified_q | (64'h1 << `SSSR_VEC_COMP)) :
                    64'hffff_ffff_ffff_ffff);
            end
            if (state_q == SSSR_APPLY && !(!comp_q[`SSSR_COMP_BIT] ||
                (comp_q[62:0] & ~enabled[62:0]) != 63'h0 ||
                (pres_q & ~comp_q) != 64'h0 || tail_bad_q)) begin
                comp_load <= requested_component_mask_q & pres_q;
                comp_init <= requested_component_mask_q & ~pres_q;
                vcsr_init <= requested_component_mask_q[`SSSR_VEC_COMP] &
                             ~pres_q[`SSSR_VEC_COMP];
            end
        end
    end

    // ------------------------------------------------------------------
    // Tracking and last restore record.
    // ------------------------------------------------------------------
    logic hdr_ok;
    assign hdr_ok = state_q == SSSR_APPLY && comp_q[`SSSR_COMP_BIT] &&
                    (comp_q[62:0] & ~enabled[62:0]) == 63'h0 &&
                    (pres_q & ~comp_q) == 64'h0 && !tail_bad_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_use_q   <= 64'h0;
            modified_q <= 64'hffff_ffff_ffff_ffff;
        end else if (hdr_ok) begin
            in_use_q   <= (in_use_q & ~requested_component_mask_q) | (requested_component_mask_q & pres_q) |
                          in_use_set;
            modified_q <= ~requested_component_mask_q | modified_set;
        end else begin
            in_use_q   <= in_use_q | in_use_set;
            modified_q <= modified_q | modified_set;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rec_priv_q   <= 2'h0;
            rec_guest_q  <= 1'b0;
            rec_addr_q   <= 64'h0;
            rec_bitmap_q <= 64'h0;
        end else if (hdr_ok) begin
            rec_priv_q   <= cur_priv;
            rec_guest_q  <= guest_mode;
            rec_addr_q   <= addr_q;
            rec_bitmap_q <= comp_q;
        end
    end

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    a_entry_fault_quiet: assert property (@(posedge clk) disable iff (rst)
        state_q == SSSR_IDLE && start && entry_fault != SSSR_F_NONE
        |=> done && !mem_wr && !mem_rd && state_q == SSSR_IDLE)
        else $error("entry fault touched memory");
    a_ud_first: assert property (@(posedge clk) disable iff (rst)
        state_q == SSSR_IDLE && start && !save_feature_enable
        |=> fault == SSSR_F_UD)
        else $error("undefined opcode fault missing");
    a_gp_priv: assert property (@(posedge clk) disable iff (rst)
        state_q == SSSR_IDLE && start && save_feature_enable &&
        !ctrl_flags[`SSSR_TS_BIT] && cur_priv != 2'h0
        |=> fault == SSSR_F_GP)
        else $error("privilege fault missing");
    sequence s_save_hdr;
        mem_wr && mem_addr == addr_q + `SSSR_HDR_PRES_OFS ##1
        mem_wr && mem_addr == addr_q + `SSSR_HDR_COMP_OFS;
    endsequence
    a_save_header: assert property (@(posedge clk) disable iff (rst)
        state_q == SSSR_WPRES |=> s_save_hdr ##1 !mem_wr)
        else $error("save header writes wrong");
    a_comp_word: assert property (@(posedge clk) disable iff (rst)
        state_q == SSSR_WCOMP |=> mem_wdata[63] &&
        mem_wdata[62:0] == $past(requested_component_mask_q[62:0]))
        else $error("compaction bitmap wrong");
    a_pres_masked: assert property (@(posedge clk) disable iff (rst)
        state_q == SSSR_WPRES |=> (mem_wdata & ~$past(requested_component_mask_q)) == 64'h0)
        else $error("present bit outside request");
    a_restore_reads: assert property (@(posedge clk) disable iff (rst)
        state_q == SSSR_IDLE && start_restore && entry_fault == SSSR_F_NONE
        |=> ##1 mem_rd [*8])
        else $error("header read burst wrong");
    a_load_init_split: assert property (@(posedge clk) disable iff (rst)
        (comp_load & comp_init) == 64'h0)
        else $error("component both loaded and initialised");
    a_track_unreq: assert property (@(posedge clk) disable iff (rst)
        hdr_ok |=> (modified_q & ~$past(requested_component_mask_q)) == ~$past(requested_component_mask_q))
        else $error("modified bit not set for unrequested");
endmodule : sssr_seq
`default_nettype wire

// ==== testbench/sssr_mem.sv ====
// Memory model holding the save area seen by the sequencer.
// Assumes one clock; read data stand in the cycle in which the strobe
// stands, one cycle after the sequencer decided on the read.
`timescale 1ns/1ps
`default_nettype none
module sssr_mem (
    // Clock.
    input  wire logic        clk,
    // Word port from the sequencer.
    input  wire logic        mem_wr,
    input  wire logic        mem_rd,
    input  wire logic [63:0] mem_addr,
    input  wire logic [63:0] mem_wdata,
    output logic      [63:0] mem_rdata
);
    logic [63:0] store [logic [63:0]];
    logic [63:0] last_q = 64'h0;
    int          n_wr   = 0;
    int          n_rd   = 0;
    // Outside a read answer the data flip, so stale data never match.
    always @(mem_rd or mem_addr or last_q) begin
        if (mem_rd) begin
            mem_rdata = store.exists(mem_addr) ? store[mem_addr] : '1;
        end else begin
            mem_rdata = ~last_q;
        end
    end
    always @(posedge clk) begin
        if (mem_wr) begin
            store[mem_addr] = mem_wdata;
            n_wr++;
        end
        if (mem_rd) begin
            n_rd++;
        end
        last_q <= mem_rdata;
    end
endmodule : sssr_mem
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the save and restore sequencer.
// Assumes the sequencer, its package and the memory model are compiled.
`timescale 1ns/1ps
`default_nettype none
`include "sssr_regs.svh"
module testbench;
    import sssr_pkg::*;
    logic        clk = 1'b0, rst = 1'b1;
    logic        start_save = 1'b0, start_restore = 1'b0;
    logic        save_feature_enable = 1'b1, guest_mode = 1'b0;
    logic [1:0]  cur_priv = 2'h0;
    logic [31:0] ctrl_flags = 32'h0, vcsr_in = `SSSR_VCSR_INIT;
    logic [63:0] instr_mask = '0, area_addr = '0, comp_bad_value = '0;
    logic [63:0] in_use_set = '0, modified_set = '0;
    logic [63:0] user_enable_mask = 64'hff, sup_enable_mask = 64'h100;
    logic [63:0] sup_comp_mask = 64'h100;
    logic        mem_wr, mem_rd, vcsr_init, done, acc_vi;
    logic [63:0] mem_addr, mem_wdata, mem_rdata, in_use_q, modified_q;
    logic [63:0] comp_save, comp_load, comp_init, acc_save, acc_load, acc_init;
    sssr_fault_t fault;
    int          fails = 0, n_compared = 0, cycles = 0, wr0, rd0;

    sssr_seq sssr_seq_i (.clk, .rst, .start_save, .start_restore,
        .instr_mask, .area_addr, .user_enable_mask, .sup_enable_mask,
        .save_feature_enable, .ctrl_flags, .cur_priv, .guest_mode,
        .vcsr_in, .sup_comp_mask, .comp_bad_value, .mem_wr, .mem_rd,
        .mem_addr, .mem_wdata, .mem_rdata, .comp_save, .comp_load,
        .comp_init, .vcsr_init, .in_use_set, .modified_set, .in_use_q,
        .modified_q, .done, .fault);
    sssr_mem mem_i (.clk, .mem_wr, .mem_rd, .mem_addr, .mem_wdata,
        .mem_rdata);

    always #20 clk = ~clk;
    // Transfer pulses are gathered so each operation is judged as a whole.
    always @(posedge clk) begin
        acc_save |= comp_save;
        acc_load |= comp_load;
        acc_init |= comp_init;
        acc_vi   |= vcsr_init;
        cycles++;
        if (cycles == 4000) begin
            fails++;
            conclude();
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic conclude();
        if (fails == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic run(input logic rs, input logic [63:0] m, a);
        int k;
        k = 0;
        @(posedge clk);
        start_save    <= !rs;
        start_restore <= rs;
        instr_mask    <= m;
        area_addr     <= a;
        {acc_save, acc_load, acc_init, acc_vi} = '0;
        wr0 = mem_i.n_wr;
        rd0 = mem_i.n_rd;
        @(posedge clk);
        start_save    <= 1'b0;
        start_restore <= 1'b0;
        #1;
        while (done !== 1'b1) begin
            if (k++ > 40) begin
                fails++;
                break;
            end
            @(posedge clk);
            #1;
        end
    endtask : run

    function automatic logic [63:0] word(input logic [63:0] a, input int k);
        return mem_i.store[a + `SSSR_HDR_PRES_OFS + 64'(8 * k)];
    endfunction : word

    task automatic hdr(input logic [63:0] a, p, c, input int k,
                       input logic [63:0] v);
        mem_i.store[a + `SSSR_HDR_PRES_OFS] = p;
        mem_i.store[a + `SSSR_HDR_COMP_OFS] = c;
        for (int j = 2; j < 8; j++) begin
            mem_i.store[a + `SSSR_HDR_PRES_OFS + 64'(8 * j)] = (j == k) ? v : '0;
        end
    endtask : hdr

    task automatic pulse(input logic [63:0] iu, md);
        @(posedge clk);
        in_use_set   <= iu;
        modified_set <= md;
        @(posedge clk);
        in_use_set   <= '0;
        modified_set <= '0;
    endtask : pulse

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_entry();
        logic [63:0] iu;
        sssr_fault_t ef;
        for (int i = 0; i < 8; i++) begin
            iu = in_use_q;
            save_feature_enable <= (i % 4) != 0;
            ctrl_flags <= ((i % 4) < 2) ? 32'h8 : 32'h0;
            cur_priv <= ((i % 4) == 3) ? 2'h0 : 2'h1;
            ef = (i % 4 == 0) ? SSSR_F_UD : (i % 4 == 1) ? SSSR_F_NM : SSSR_F_GP;
            run(i >= 4, 64'h1f3, 64'h1020);
            check(64'(fault), 64'(ef));
            check(64'(mem_i.n_wr + mem_i.n_rd - wr0 - rd0), '0);
            check(acc_save | acc_load | acc_init, '0);
            check(in_use_q, iu);
        end
        save_feature_enable <= 1'b1;
        ctrl_flags <= 32'h0;
        cur_priv <= 2'h0;
    endtask : t_entry

    task automatic t_save();
        for (int i = 0; i < 2; i++) begin
            vcsr_in <= i ? 32'h0000_1f81 : `SSSR_VCSR_INIT;
            mem_i.store[64'h1210] = 64'h5a5a_5a5a_5a5a_5a5a;
            run(1'b0, 64'hffff_0000_0000_01f3, 64'h1000);
            check(word(64'h1000, 0), i ? 64'h52 : 64'h50);
            check(word(64'h1000, 1), 64'h8000_0000_0000_01f3);
            check(acc_save, i ? 64'h52 : 64'h50);
            check(64'(mem_i.n_wr - wr0), 64'h2);
            check(word(64'h1000, 2), 64'h5a5a_5a5a_5a5a_5a5a);
        end
        vcsr_in <= `SSSR_VCSR_INIT;
    endtask : t_save

    task automatic t_restore();
        logic [63:0] iu;
        iu = in_use_q;
        hdr(64'h2000, 64'h110, 64'h8000_0000_0000_01f3, 0, '0);
        run(1'b1, 64'h116, 64'h2000);
        check(64'(fault), 64'(SSSR_F_NONE));
        check(64'(mem_i.n_rd - rd0), 64'h8);
        check(acc_load, 64'h110);
        check(acc_init, 64'h6);
        check(64'(acc_vi), 64'h1);
        check(in_use_q, (iu & ~64'h116) | 64'h110);
        check(modified_q, ~64'h116);
    endtask : t_restore

    task automatic t_modopt();
        for (int i = 0; i < 3; i++) begin
            guest_mode <= (i == 1);
            run(1'b0, 64'h1f3, (i == 2) ? 64'h3000 : 64'h2000);
            check(acc_save, (i == 0) ? 64'h140 : 64'h150);
            check(word((i == 2) ? 64'h3000 : 64'h2000, 0), 64'h150);
        end
        guest_mode <= 1'b0;
    endtask : t_modopt

    task automatic t_badhdr();
        logic [63:0] iu, c;
        for (int i = 0; i < 4; i++) begin
            iu = in_use_q;
            c = (i == 1) ? 64'h8000_0000_0000_0211 : 64'h8000_0000_0000_01f3;
            c[63] = (i != 0);
            hdr(64'h4000, (i == 2) ? 64'h18 : 64'h10, c, (i == 3) ? 5 : 0, 64'h1);
            run(1'b1, 64'h116, 64'h4000);
            check(64'(fault), 64'(SSSR_F_GP));
            check(acc_load | acc_init, '0);
            check(in_use_q, iu);
        end
    endtask : t_badhdr

    task automatic t_compbad();
        hdr(64'h5000, 64'h112, 64'h8000_0000_0000_01f3, 0, '0);
        for (int i = 0; i < 3; i++) begin
            comp_bad_value <= (i == 0) ? 64'h100 : (i == 1) ? 64'h10 : '0;
            vcsr_in <= (i == 2) ? 32'h0001_1f80 : `SSSR_VCSR_INIT;
            run(1'b1, 64'h116, 64'h5000);
            check(64'(fault), 64'((i == 1) ? SSSR_F_NONE : SSSR_F_GP));
            check(acc_load, 64'h112);
        end
        comp_bad_value <= '0;
        vcsr_in <= `SSSR_VCSR_INIT;
    endtask : t_compbad

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check(in_use_q, '0);
        check(modified_q, '1);
        check(64'(fault), 64'(SSSR_F_NONE));
        t_entry();
        pulse(64'hc50, '0);
        t_save();
        t_restore();
        pulse('0, 64'h100);
        t_modopt();
        t_badhdr();
        t_compbad();
        conclude();
    end
endmodule : testbench
`default_nettype wire
